// ---- rtl/wfgc_params.svh ----
// constants for the waveform generator control register block
`ifndef WFGC_PARAMS_SVH
`define WFGC_PARAMS_SVH
`define WFGC_ADDR_W        4
`define WFGC_OFF_CTRL0     4'h0
`define WFGC_OFF_CTRL2     4'h4
`define WFGC_OFF_STATUS    4'h8
`define WFGC_CTRL0_RESET   8'h00
`define WFGC_CTRL0_WMASK   8'hf9
`define WFGC_CTRL2_RESET   8'h00
`define WFGC_CTRL2_WMASK   8'h03
`define WFGC_BIT_EN        7
`define WFGC_BIT_OEB       6
`define WFGC_BIT_OEA       5
`define WFGC_BIT_POLB      4
`define WFGC_BIT_POLA      3
`define WFGC_BIT_CS        0
`define WFGC_BIT_OVRA      0
`define WFGC_BIT_OVRB      1
`endif

// ---- rtl/wfgc_pkg.sv ----
// types for the waveform generator control register block
package wfgc_pkg;
   typedef struct packed {
      logic module_enable;
      logic second_output_pin_enable;
      logic first_output_pin_enable;
      logic second_output_invert;
      logic first_output_invert;
      logic [1:0] unused;
      logic clock_source_select;
   } wfgc_ctrl0_type;

   typedef struct packed {
      logic first_out;
      logic second_out;
   } wfgc_pair_type;

   typedef enum logic [1:0] {
      WFGC_IDLE,
      WFGC_ACK
   } wfgc_bus_state_type;
endpackage : wfgc_pkg

// ---- rtl/wfgc_sync2.sv ----
// two flip-flop synchroniser for a pin level
`timescale 1ns/10ps
module wfgc_sync2 (
   input  wire logic ref_clk_i,
   input  wire logic rst_b_i,
   input  wire logic async_i,
   output logic      sync_o
);
   logic meta_q;

   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         meta_q <= 1'b0;
         sync_o <= 1'b0;
      end else begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule : wfgc_sync2

// ---- rtl/wfgc_out_stage.sv ----
// one output path: polarity, override select and pin gate
`timescale 1ns/10ps
module wfgc_out_stage (
   input  wire logic ref_clk_i,
   input  wire logic rst_b_i,
   input  wire logic run_i,
   input  wire logic wave_i,
   input  wire logic invert_i,
   input  wire logic shutdown_i,
   input  wire logic override_i,
   input  wire logic pin_en_i,
   output logic      pin_o,
   output logic      pin_oe_o
);
   logic level_d;

   always_comb begin
      // override level bypasses the polarity stage
      if (shutdown_i) begin
         level_d = override_i;
      end else begin
         level_d = run_i & (wave_i ^ invert_i);
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         pin_o    <= 1'b0;
         pin_oe_o <= 1'b0;
      end else begin
         pin_o    <= pin_en_i & level_d;
         pin_oe_o <= pin_en_i;
      end
   end
endmodule : wfgc_out_stage

// ---- rtl/wfgc_ctrl.sv ----
// waveform generator control register 0 with wishbone slave and pin stage
//
// Functional notes
// - bit 7 enables the generator
// - bit 6 gates second output onto pin
// - bit 5 gates first output onto pin
// - bits 4 and 3 invert second/first output
// - override levels skip polarity inversion
// - keep fast oscillator on in sleep while enabled, fast clock selected and source active
//
// Design decisions made here: the Wishbone register port and the register addresses.
`timescale 1ns/10ps
`include "wfgc_params.svh"
module wfgc_ctrl (
   input  wire logic                    ref_clk_i,
   input  wire logic                    rst_b_i,
   // ---------------------------------------------------------------
   // wishbone classic slave
   // ---------------------------------------------------------------
   input  wire logic                    wb_cyc_i,
   input  wire logic                    wb_stb_i,
   input  wire logic                    wb_we_i,
   input  wire logic [`WFGC_ADDR_W-1:0] wb_adr_i,
   input  wire logic [31:0]             wb_dat_i,
   input  wire logic [3:0]              wb_sel_i,
   output logic      [31:0]             wb_dat_o,
   output logic                         wb_ack_o,
   output logic                         wb_err_o,
   // ---------------------------------------------------------------
   // generator side
   // ---------------------------------------------------------------
   input  wire logic                    wave_src_i,
   input  wire logic                    src_active_i,
   input  wire logic                    shutdown_pin_i,
   input  wire logic                    sleep_i,
   output logic                         gen_clk_fast_o,
   output logic                         fast_osc_keep_o,
   output logic                         gen_run_o,
   output logic                         first_pin_o,
   output logic                         first_pin_oe_o,
   output logic                         second_pin_o,
   output logic                         second_pin_oe_o
);
   wfgc_pkg::wfgc_ctrl0_type  ctrl0_q;
   logic [7:0]                ctrl2_q;
   wfgc_pkg::wfgc_bus_state_type bus_q;
   wfgc_pkg::wfgc_pair_type   wave_q;
   logic                      wave_s;
   logic                      shut_s;
   logic                      req;
   logic                      hit_ctrl0;
   logic                      hit_ctrl2;
   logic                      hit_stat;
   logic                      mapped;
   logic [7:0]                rd_byte;
   logic [7:0]                stat_byte;
   logic                      shutdown;

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   wfgc_sync2 u_sync_wave (
      .ref_clk_i (ref_clk_i),
      .rst_b_i   (rst_b_i),
      .async_i   (wave_src_i),
      .sync_o    (wave_s)
   );

   wfgc_sync2 u_sync_shut (
      .ref_clk_i (ref_clk_i),
      .rst_b_i   (rst_b_i),
      .async_i   (shutdown_pin_i),
      .sync_o    (shut_s)
   );

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   assign req       = wb_cyc_i & wb_stb_i & (bus_q == wfgc_pkg::WFGC_IDLE);
   assign hit_ctrl0 = (wb_adr_i == `WFGC_OFF_CTRL0);
   assign hit_ctrl2 = (wb_adr_i == `WFGC_OFF_CTRL2);
   assign hit_stat  = (wb_adr_i == `WFGC_OFF_STATUS);
   assign mapped    = hit_ctrl0 | hit_ctrl2 | hit_stat;

   assign shutdown  = shut_s;
   assign stat_byte = {4'h0, shutdown, fast_osc_keep_o, wave_q.first_out,
                       gen_run_o};

   always_comb begin
      rd_byte = 8'h00;
      if (hit_ctrl0) begin
         rd_byte = ctrl0_q & `WFGC_CTRL0_WMASK;
      end else if (hit_ctrl2) begin
         rd_byte = ctrl2_q & `WFGC_CTRL2_WMASK;
      end else if (hit_stat) begin
         rd_byte = stat_byte;
      end
   end

   // one ack (mapped) or err (unmapped) per request, dropped the next cycle
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         bus_q    <= wfgc_pkg::WFGC_IDLE;
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         case (bus_q)
            wfgc_pkg::WFGC_IDLE: begin
               wb_ack_o <= req & mapped;
               wb_err_o <= req & ~mapped;
               if (req) begin
                  bus_q    <= wfgc_pkg::WFGC_ACK;
                  wb_dat_o <= {24'h00_0000, rd_byte};
               end
            end
            wfgc_pkg::WFGC_ACK: begin
               wb_ack_o <= 1'b0;
               wb_err_o <= 1'b0;
               bus_q    <= wfgc_pkg::WFGC_IDLE;
            end
            default: begin
               bus_q    <= wfgc_pkg::WFGC_IDLE;
               wb_ack_o <= 1'b0;
               wb_err_o <= 1'b0;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // control registers
   // ---------------------------------------------------------------
   // software is expected to clear enable before reconfiguring
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         ctrl0_q <= `WFGC_CTRL0_RESET;
      end else if (req && wb_we_i && hit_ctrl0 && wb_sel_i[0]) begin
         ctrl0_q <= wb_dat_i[7:0] & `WFGC_CTRL0_WMASK;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         ctrl2_q <= `WFGC_CTRL2_RESET;
      end else if (req && wb_we_i && hit_ctrl2 && wb_sel_i[0]) begin
         ctrl2_q <= wb_dat_i[7:0] & `WFGC_CTRL2_WMASK;
      end
   end

   // ---------------------------------------------------------------
   // generator core
   // ---------------------------------------------------------------
   assign gen_run_o      = ctrl0_q[`WFGC_BIT_EN];
   assign gen_clk_fast_o = ctrl0_q[`WFGC_BIT_CS];
   // sleep does not stop the fast oscillator while it is in use
   assign fast_osc_keep_o = gen_run_o & src_active_i
                            & gen_clk_fast_o;

   // complementary pair; dead band lives elsewhere
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         wave_q <= 2'b00;
      end else if (gen_run_o) begin
         wave_q.first_out  <= wave_s;
         wave_q.second_out <= ~wave_s;
      end else begin
         wave_q <= 2'b00;
      end
   end

   wfgc_out_stage u_first (
      .ref_clk_i  (ref_clk_i),
      .rst_b_i    (rst_b_i),
      .run_i      (gen_run_o),
      .wave_i     (wave_q.first_out),
      .invert_i   (ctrl0_q[`WFGC_BIT_POLA]),
      .shutdown_i (shutdown),
      .override_i (ctrl2_q[`WFGC_BIT_OVRA]),
      .pin_en_i   (ctrl0_q[`WFGC_BIT_OEA]),
      .pin_o      (first_pin_o),
      .pin_oe_o   (first_pin_oe_o)
   );

   wfgc_out_stage u_second (
      .ref_clk_i  (ref_clk_i),
      .rst_b_i    (rst_b_i),
      .run_i      (gen_run_o),
      .wave_i     (wave_q.second_out),
      .invert_i   (ctrl0_q[`WFGC_BIT_POLB]),
      .shutdown_i (shutdown),
      .override_i (ctrl2_q[`WFGC_BIT_OVRB]),
      .pin_en_i   (ctrl0_q[`WFGC_BIT_OEB]),
      .pin_o      (second_pin_o),
      .pin_oe_o   (second_pin_oe_o)
   );

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   property p_enable_runs;
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      (req && wb_we_i && hit_ctrl0 && wb_sel_i[0])
      |=> gen_run_o == $past(wb_dat_i[`WFGC_BIT_EN]);
   endproperty
   a_enable_runs: assert property (p_enable_runs)
      else $error("run does not follow enable");

   property p_second_gate;
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      !ctrl0_q[`WFGC_BIT_OEB] |=> !second_pin_oe_o && !second_pin_o;
   endproperty
   a_second_gate: assert property (p_second_gate)
      else $error("second output reached pin while gated");

   property p_first_gate;
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      !ctrl0_q[`WFGC_BIT_OEA] |=> !first_pin_oe_o && !first_pin_o;
   endproperty
   a_first_gate: assert property (p_first_gate)
      else $error("first output reached pin while gated");

   property p_first_polarity;
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      (ctrl0_q[`WFGC_BIT_OEA] && gen_run_o && !shutdown)
      |=> first_pin_o == ($past(wave_q.first_out)
                          ^ $past(ctrl0_q[`WFGC_BIT_POLA]));
   endproperty
   a_first_polarity: assert property (p_first_polarity)
      else $error("first output polarity wrong");

   property p_second_polarity;
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      (ctrl0_q[`WFGC_BIT_OEB] && gen_run_o && !shutdown)
      |=> second_pin_o == ($past(wave_q.second_out)
                           ^ $past(ctrl0_q[`WFGC_BIT_POLB]));
   endproperty
   a_second_polarity: assert property (p_second_polarity)
      else $error("second output polarity wrong");

   property p_unused_zero;
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      (wb_ack_o && $past(hit_ctrl0)) |-> wb_dat_o[2:1] == 2'b00;
   endproperty
   a_unused_zero: assert property (p_unused_zero)
      else $error("unimplemented bits read nonzero");

   property p_override;
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      (shutdown && ctrl0_q[`WFGC_BIT_OEA])
      |=> first_pin_o == $past(ctrl2_q[`WFGC_BIT_OVRA]);
   endproperty
   a_override: assert property (p_override)
      else $error("override level altered");

   property p_keep_osc;
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      (sleep_i && gen_run_o && src_active_i && gen_clk_fast_o)
      |-> fast_osc_keep_o;
   endproperty
   a_keep_osc: assert property (p_keep_osc)
      else $error("fast oscillator dropped in sleep");

   property p_ack_once;
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_once: assert property (p_ack_once)
      else $error("ack held two cycles");

   property p_first_oe;
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      ctrl0_q[`WFGC_BIT_OEA] |=> first_pin_oe_o;
   endproperty
   a_first_oe: assert property (p_first_oe)
      else $error("first pin enable did not follow its bit");

   property p_second_oe;
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      ctrl0_q[`WFGC_BIT_OEB] |=> second_pin_oe_o;
   endproperty
   a_second_oe: assert property (p_second_oe)
      else $error("second pin enable did not follow its bit");

   // a stopped generator leaves both pins low outside shutdown
   property p_disabled_low;
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      (!gen_run_o && !shutdown) |=> !first_pin_o && !second_pin_o;
   endproperty
   a_disabled_low: assert property (p_disabled_low)
      else $error("pins driven while generator disabled");

   property p_masked_write;
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      (req && wb_we_i && !(hit_ctrl0 && wb_sel_i[0])) |=> $stable(ctrl0_q);
   endproperty
   a_masked_write: assert property (p_masked_write)
      else $error("control register changed without a lane 0 write");

   c_write_ctrl0: cover property (@(posedge ref_clk_i)
      req && wb_we_i && hit_ctrl0);
   c_run_shut: cover property (@(posedge ref_clk_i)
      gen_run_o && shutdown);
   c_bad_addr: cover property (@(posedge ref_clk_i) wb_err_o);
   c_invert_both: cover property (@(posedge ref_clk_i)
      gen_run_o && ctrl0_q[`WFGC_BIT_POLA] && ctrl0_q[`WFGC_BIT_POLB]);
   c_keep_sleep: cover property (@(posedge ref_clk_i)
      sleep_i && fast_osc_keep_o);
endmodule : wfgc_ctrl

// ---- tb/wfgc_src_model.sv ----
// waveform source model driving the generator input
`timescale 1ns/10ps
module wfgc_src_model (
   input  wire logic ref_clk_i,
   input  wire logic rst_b_i,
   input  wire logic level_i,
   output logic      wave_o
);
   // ------------------------------------------------------------
   // source level
   // ------------------------------------------------------------
   // changes only after an edge, as a synchronous source would
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         wave_o <= 1'b0;
      end else begin
         wave_o <= level_i;
      end
   end
endmodule : wfgc_src_model

// ---- tb/tb.sv ----
// self-checking bench for the waveform control register block
`timescale 1ns/10ps
module tb;
   logic        ref_clk_i, rst_b_i, wb_cyc_i, wb_stb_i, wb_we_i;
   logic [3:0]  wb_adr_i, wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic        wb_ack_o, wb_err_o, wave, lvl, sd, act, slp;
   logic        clk_fast, keep, run, p1, p1_oe, p2, p2_oe, er;
   logic [31:0] rd;
   logic [7:0]  m_c0, m_c2, v;
   int          n_mismatch, total_checks, k;

   wfgc_src_model src (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
      .level_i(lvl), .wave_o(wave));
   wfgc_ctrl uut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
      .wave_src_i(wave), .src_active_i(act), .shutdown_pin_i(sd),
      .sleep_i(slp), .gen_clk_fast_o(clk_fast), .fast_osc_keep_o(keep),
      .gen_run_o(run), .first_pin_o(p1), .first_pin_oe_o(p1_oe),
      .second_pin_o(p2), .second_pin_oe_o(p2_oe));

   initial begin
      ref_clk_i = 1'b0;
      forever #2.5 ref_clk_i = ~ref_clk_i;
   end

   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : results

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // ------------------------------------------------------------
   // wishbone classic cycle
   // ------------------------------------------------------------
   task automatic wb(input logic we, input logic [3:0] a,
                     input logic [7:0] d, input logic [3:0] s);
      int i;
      i = 0;
      @(posedge ref_clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= {24'h000000, d};
      wb_sel_i <= s;
      do begin
         @(posedge ref_clk_i);
         i++;
      end while (i < 20 && wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
      if (i >= 20) begin
         n_mismatch++;
         results();
      end
      // answer taken and request dropped at the ack edge, so a held
      // strobe is never taken a second time
      rd = wb_dat_o;
      er = wb_err_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask : wb

   // write with the model following the register rules
   task automatic wr(input logic [3:0] a, input logic [7:0] d,
                     input logic [3:0] s);
      wb(1'b1, a, d, s);
      check(er, a != 4'h0 && a != 4'h4 && a != 4'h8);
      if (s[0] && a == 4'h0) m_c0 = d & 8'hf9;
      if (s[0] && a == 4'h4) m_c2 = d & 8'h03;
   endtask : wr

   task automatic rdc(input logic [3:0] a);
      wb(1'b0, a, 8'h00, 4'hf);
      check(er, a != 4'h0 && a != 4'h4 && a != 4'h8);
      if (a == 4'h0) check(rd, {24'h000000, m_c0});
      if (a == 4'h4) check(rd, {24'h000000, m_c2});
      if (a == 4'h8) check(rd, {24'h000000, 3'b000, sd,
         m_c0[7] & act & m_c0[0], m_c0[7] & lvl, m_c0[7]});
   endtask : rdc

   task automatic drv(input logic l, input logic s, input logic a);
      @(posedge ref_clk_i);
      lvl <= l;
      sd  <= s;
      act <= a;
      slp <= $urandom;
   endtask : drv

   // steady-state view of the pins against the model
   task automatic settle;
      logic en;
      logic e1;
      logic e2;
      repeat (8) @(negedge ref_clk_i);
      en = m_c0[7];
      e1 = m_c0[5] & (sd ? m_c2[0] : en & (lvl ^ m_c0[3]));
      e2 = m_c0[6] & (sd ? m_c2[1] : en & (~lvl ^ m_c0[4]));
      check(run, en);
      check(p2_oe, m_c0[6]);
      check(p1_oe, m_c0[5]);
      check({p1, p2}, {e1, e2});
      check(clk_fast, m_c0[0]);
      check(keep, en & act & m_c0[0]);
      rdc(4'h8);
   endtask : settle

   initial begin
      {rst_b_i, wb_cyc_i, wb_stb_i, wb_we_i, lvl, sd, act, slp} = 8'h00;
      {wb_adr_i, wb_sel_i, wb_dat_i} = 40'h0;
      {m_c0, m_c2, n_mismatch, total_checks} = 0;
      void'($urandom(44388));
      repeat (4) @(posedge ref_clk_i);
      rst_b_i <= 1'b1;
      rdc(4'h0);
      rdc(4'h4);
      settle();
      $display("test reset values done");
      // all ones written to control 0 with enable set, then a write without lane 0 that must not change it
      wr(4'h0, 8'hff, 4'hf);
      rdc(4'h0);
      wr(4'h0, 8'h00, 4'he);
      rdc(4'h0);
      wr(4'hc, 8'h55, 4'hf);
      rdc(4'hc);
      $display("test reserved and unmapped done");
      for (k = 0; k < 16; k++) begin
         v = $urandom;
         drv($urandom, 1'b0, $urandom);
         wr(4'h0, v, 4'hf);
         rdc(4'h0);
         settle();
      end
      $display("test random config done");
      for (k = 0; k < 8; k++) begin
         drv(k[2], 1'b0, 1'b1);
         wr(4'h0, {3'b111, k[1:0], 3'b001}, 4'hf);
         settle();
      end
      $display("test polarity table done");
      for (k = 0; k < 16; k++) begin
         wr(4'h4, {6'h00, k[1:0]}, 4'hf);
         wr(4'h0, {3'b111, k[3:2], 3'b000}, 4'hf);
         drv(k[0], 1'b1, 1'b0);
         settle();
      end
      drv(1'b0, 1'b0, 1'b1);
      $display("test shutdown override done");
      wr(4'h0, 8'he9, 4'hf);
      @(posedge ref_clk_i);
      rst_b_i <= 1'b0;
      @(posedge ref_clk_i);
      rst_b_i <= 1'b1;
      {m_c0, m_c2} = 16'h0000;
      settle();
      rdc(4'h0);
      $display("test mid-run reset done");
      results();
   end
endmodule : tb
